/* src/dsc_exec_pkg.sv */
/*
 package of the operand and arithmetic execution datapath: widths,
 operation codes, register numbers, bus offsets, flag positions and
 values after reset.
 assumes nothing of its surroundings.
*/
package dsc_exec_pkg;

   localparam int WORD_W   = 16;
   localparam int NUM_WORK = 16;
   localparam int ACC_W    = 40;

   typedef enum logic [3:0] {
      OP_NONE,
      OP_SUM_WITH_CARRY_OP_FILE,
      OP_SUM_WITH_CARRY_OP_TEN_BIT_LITERAL,
      OP_SUM_WITH_CARRY_OP_REG,
      OP_SUM_WITH_CARRY_OP_FIVE_BIT_LITERAL,
      OP_ADD_ACC,
      OP_ASR_FILE,
      OP_ASR_REG,
      OP_ASR_BY_REG,
      OP_ASR_BY_FIVE_BIT_LITERAL,
      OP_MAC,
      OP_SQR,
      OP_DIV
   } op_type;

   localparam logic [3:0] DEFAULT_WORK_IDX = 4'h0;
   localparam logic [3:0] DSP_FIRST_IDX    = 4'h4;
   localparam logic [3:0] X_PTR_IDX        = 4'h8;
   localparam logic [3:0] Y_PTR_IDX        = 4'hA;
   localparam logic [3:0] INDEX_IDX        = 4'hC;

   localparam logic [2:0] MOD_PLAIN   = 3'h0;
   localparam logic [2:0] MOD_INC2    = 3'h1;
   localparam logic [2:0] MOD_INC4    = 3'h2;
   localparam logic [2:0] MOD_INC6    = 3'h3;
   localparam logic [2:0] MOD_DEC2    = 3'h4;
   localparam logic [2:0] MOD_DEC4    = 3'h5;
   localparam logic [2:0] MOD_DEC6    = 3'h6;
   localparam logic [2:0] MOD_SPECIAL = 3'h7;

   localparam logic [7:0] OFS_CORE_STATUS = 8'h00;
   localparam logic [7:0] OFS_DSP_STATUS  = 8'h04;
   localparam logic [7:0] OFS_ACC_A_LO    = 8'h08;
   localparam logic [7:0] OFS_ACC_A_HI    = 8'h0C;
   localparam logic [7:0] OFS_ACC_B_LO    = 8'h10;
   localparam logic [7:0] OFS_ACC_B_HI    = 8'h14;
   localparam logic [7:0] OFS_WORK_BASE   = 8'h40;

   localparam int C_BIT  = 0;
   localparam int DC_BIT = 1;
   localparam int N_BIT  = 2;
   localparam int OV_BIT = 3;
   localparam int Z_BIT  = 4;
   localparam int OA_BIT = 0;
   localparam int OB_BIT = 1;
   localparam int SA_BIT = 2;
   localparam int SB_BIT = 3;

   localparam logic [4:0]  CORE_STATUS_RST = 5'h00;
   localparam logic [3:0]  DSP_STATUS_RST  = 4'h0;
   localparam logic [15:0] WORK_RST        = 16'h0000;
   localparam logic [39:0] ACC_RST         = 40'h00_0000_0000;

endpackage : dsc_exec_pkg

/* src/asr_unit.sv */
/*
 arithmetic right shifter, sign filling, parameterised width.
 assumes a purely combinational use by its parent.
*/
`timescale 1ns/1ps
module asr_unit #(
   parameter int W  = 16,
   parameter int SW = 5
) (
   input  wire logic [W-1:0]  data_in,
   input  wire logic [SW-1:0] amount,
   output logic      [W-1:0]  data_out
);

   // sign bit fills the vacated upper positions
   assign data_out = W'($signed(data_in) >>> amount);

endmodule : asr_unit

/* src/dsc_operand_and_arith_exec.sv */
/*
 execution datapath: working registers, carry-in additions, signed
 accumulator add, arithmetic right shifts, dsp operand checks and
 prefetch addressing, with an avalon-mm slave for software access.
 assumes decode drives one operation per cycle with OP_VALID and
 synchronous inputs on REF_CLK.
*/
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
// How it works
// - sixteen working registers, any selectable as operand
// - default working operand is working register zero
// - squares accept only self pairs of four-seven
// - multiplies accept six distinct pairs of four-seven
// - x prefetch from eight/nine, modified, indexed, none
// - y prefetch from ten/eleven, modified, indexed, none
// - prefetched data lands only in four-seven
// - divide operands read directly from register pair
// - signed shifted add into accumulator, accumulator flags
// - file plus default plus carry, full flags
// - ten-bit literal plus carry into register
// - base plus five-bit literal plus carry
// - file shift right one, four flags
// - register shift right one, source to destination
// - shift by register count, negative zero only
// - shift by five-bit literal, negative zero only
// - core status holds carry, nibble, sign, overflow, zero
// - dsp status holds overflow, saturation per accumulator
module dsc_operand_and_arith_exec #(
   parameter int SHIFT_CNT_W = 4
) (
   input  wire logic        REF_CLK,
   input  wire logic        RST,
   input  wire logic        OP_VALID,
   input  wire logic [3:0]  OP_CODE,
   input  wire logic [3:0]  BASE_SEL,
   input  wire logic [3:0]  SRC_SEL,
   input  wire logic [3:0]  DEST_SEL,
   input  wire logic        TO_WORK,
   input  wire logic [15:0] FILE_DATA,
   input  wire logic [9:0]  LITERAL,
   input  wire logic [3:0]  SHIFT_LITERAL,
   input  wire logic        ACC_SEL,
   input  wire logic [1:0]  MUL_A_SEL,
   input  wire logic [1:0]  MUL_B_SEL,
   input  wire logic [3:0]  X_SEL,
   input  wire logic [3:0]  Y_SEL,
   input  wire logic        X_FETCH_VALID,
   input  wire logic [15:0] X_FETCH_DATA,
   input  wire logic [1:0]  X_FETCH_DEST,
   input  wire logic        Y_FETCH_VALID,
   input  wire logic [15:0] Y_FETCH_DATA,
   input  wire logic [1:0]  Y_FETCH_DEST,
   input  wire logic [7:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic      [31:0] AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   output logic             FILE_WR,
   output logic      [15:0] FILE_WDATA,
   output logic      [4:0]  CORE_STATUS,
   output logic      [3:0]  DSP_STATUS,
   output logic             OP_ILLEGAL,
   output logic      [15:0] MUL_OPA,
   output logic      [15:0] MUL_OPB,
   output logic             MUL_GO,
   output logic             X_RD,
   output logic      [15:0] X_ADDR,
   output logic             Y_RD,
   output logic      [15:0] Y_ADDR,
   output logic             DIV_GO,
   output logic      [15:0] DIV_DIVIDEND,
   output logic      [15:0] DIV_DIVISOR
);

   logic [15:0] work_reg [dsc_exec_pkg::NUM_WORK];
   logic [4:0]  core_reg;
   logic [3:0]  dsp_reg;
   logic [39:0] acc_a_reg;
   logic [39:0] acc_b_reg;
   logic [31:0] rdata_reg;
   logic        wait_reg;
   logic        file_wr_reg;
   logic [15:0] file_wdata_reg;
   logic        illegal_reg;
   logic [15:0] mul_a_reg;
   logic [15:0] mul_b_reg;
   logic        mul_go_reg;
   logic        x_rd_reg;
   logic [15:0] x_addr_reg;
   logic        y_rd_reg;
   logic [15:0] y_addr_reg;
   logic        div_go_reg;
   logic [15:0] dividend_reg;
   logic [15:0] divisor_reg;

   dsc_exec_pkg::op_type op;
   logic [15:0] base_operand_reg;
   logic [15:0] src_operand_reg;
   logic [15:0] default_work_operand;
   logic [15:0] add_a;
   logic [15:0] add_b;
   logic [16:0] add_sum;
   logic [4:0]  nib_sum;
   logic        carry_in;
   logic [15:0] shift_in;
   logic [4:0]  shift_amt;
   logic [15:0] shift_out;
   logic [15:0] result;
   logic        wr_work;
   logic [3:0]  wr_idx;
   logic        wr_file;
   logic [4:0]  core_next;
   logic [3:0]  dsp_next;
   logic        acc_we;
   logic [39:0] acc_next;
   logic        mul_legal;
   logic        pair_ok;
   logic        x_go;
   logic [15:0] x_addr_next;
   logic        x_upd;
   logic [3:0]  x_idx;
   logic [15:0] x_ptr_next;
   logic        y_go;
   logic [15:0] y_addr_next;
   logic        y_upd;
   logic [3:0]  y_idx;
   logic [15:0] y_ptr_next;
   logic        bus_req;
   logic        bus_wr;
   logic [31:0] rd_mux;

   assign op                   = dsc_exec_pkg::op_type'(OP_CODE);
   assign base_operand_reg     = work_reg[BASE_SEL];
   assign src_operand_reg      = work_reg[SRC_SEL];
   assign default_work_operand =
      work_reg[dsc_exec_pkg::DEFAULT_WORK_IDX];
   assign carry_in = core_reg[dsc_exec_pkg::C_BIT];

   assign add_sum = {1'b0, add_a} + {1'b0, add_b} + {16'h0000, carry_in};
   assign nib_sum = {1'b0, add_a[3:0]} + {1'b0, add_b[3:0]}
                  + {4'h0, carry_in};

   asr_unit #(
      .W  (16),
      .SW (5)
   ) shifter (
      .data_in  (shift_in),
      .amount   (shift_amt),
      .data_out (shift_out)
   );

   function automatic logic [15:0] post_delta(input logic [2:0] code);
      logic [15:0] d;
      d = 16'h0000;
      unique case (code)
         dsc_exec_pkg::MOD_INC2: d = 16'h0002;
         dsc_exec_pkg::MOD_INC4: d = 16'h0004;
         dsc_exec_pkg::MOD_INC6: d = 16'h0006;
         dsc_exec_pkg::MOD_DEC2: d = 16'hFFFE;
         dsc_exec_pkg::MOD_DEC4: d = 16'hFFFC;
         dsc_exec_pkg::MOD_DEC6: d = 16'hFFFA;
         default:                d = 16'h0000;
      endcase
      return d;
   endfunction : post_delta

   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
      logic [15:0] m;
      m = old;
      if (be[0]) m[7:0] = wd[7:0];
      if (be[1]) m[15:8] = wd[15:8];
      return m;
   endfunction : merge16

   // arithmetic operation select
   always_comb begin
      add_a     = 16'h0000;
      add_b     = 16'h0000;
      shift_in  = 16'h0000;
      shift_amt = 5'h00;
      result    = 16'h0000;
      wr_work   = 1'b0;
      wr_idx    = DEST_SEL;
      wr_file   = 1'b0;
      core_next = core_reg;
      unique case (op)
         dsc_exec_pkg::OP_SUM_WITH_CARRY_OP_FILE: begin
            add_a = FILE_DATA;
            add_b = default_work_operand;
         end
         dsc_exec_pkg::OP_SUM_WITH_CARRY_OP_TEN_BIT_LITERAL: begin
            add_a = {6'h00, LITERAL};
            add_b = work_reg[DEST_SEL];
         end
         dsc_exec_pkg::OP_SUM_WITH_CARRY_OP_REG: begin
            add_a = base_operand_reg;
            add_b = src_operand_reg;
         end
         dsc_exec_pkg::OP_SUM_WITH_CARRY_OP_FIVE_BIT_LITERAL: begin
            add_a = base_operand_reg;
            add_b = {11'h000, LITERAL[4:0]};
         end
         dsc_exec_pkg::OP_ASR_FILE: begin
            shift_in  = FILE_DATA;
            shift_amt = 5'h01;
         end
         dsc_exec_pkg::OP_ASR_REG: begin
            shift_in  = src_operand_reg;
            shift_amt = 5'h01;
         end
         dsc_exec_pkg::OP_ASR_BY_REG: begin
            shift_in  = base_operand_reg;
            shift_amt = {1'b0, src_operand_reg[SHIFT_CNT_W-1:0]};
         end
         dsc_exec_pkg::OP_ASR_BY_FIVE_BIT_LITERAL: begin
            shift_in  = base_operand_reg;
            shift_amt = LITERAL[4:0];
         end
         default: begin
            add_a = 16'h0000;
         end
      endcase
      if (OP_VALID) begin
         unique case (op)
            dsc_exec_pkg::OP_SUM_WITH_CARRY_OP_FILE, dsc_exec_pkg::OP_SUM_WITH_CARRY_OP_TEN_BIT_LITERAL,
            dsc_exec_pkg::OP_SUM_WITH_CARRY_OP_REG, dsc_exec_pkg::OP_SUM_WITH_CARRY_OP_FIVE_BIT_LITERAL: begin
               result = add_sum[15:0];
               core_next[dsc_exec_pkg::C_BIT]  = add_sum[16];
               core_next[dsc_exec_pkg::DC_BIT] = nib_sum[4];
               core_next[dsc_exec_pkg::N_BIT]  = add_sum[15];
               core_next[dsc_exec_pkg::OV_BIT] = (add_a[15] == add_b[15])
                                          && (add_sum[15] != add_a[15]);
               // sticky zero: only a nonzero result clears it
               if (add_sum[15:0] != 16'h0000)
                  core_next[dsc_exec_pkg::Z_BIT] = 1'b0;
               if (op == dsc_exec_pkg::OP_SUM_WITH_CARRY_OP_FILE) begin
                  wr_file = ~TO_WORK;
                  wr_work = TO_WORK;
                  wr_idx  = dsc_exec_pkg::DEFAULT_WORK_IDX;
               end else begin
                  wr_work = 1'b1;
               end
            end
            dsc_exec_pkg::OP_ASR_FILE, dsc_exec_pkg::OP_ASR_REG: begin
               result = shift_out;
               core_next[dsc_exec_pkg::C_BIT]  = shift_in[0];
               core_next[dsc_exec_pkg::N_BIT]  = shift_out[15];
               core_next[dsc_exec_pkg::OV_BIT] = 1'b0;
               core_next[dsc_exec_pkg::Z_BIT]  = (shift_out == 16'h0000);
               if (op == dsc_exec_pkg::OP_ASR_FILE) begin
                  wr_file = ~TO_WORK;
                  wr_work = TO_WORK;
                  wr_idx  = dsc_exec_pkg::DEFAULT_WORK_IDX;
               end else begin
                  wr_work = 1'b1;
               end
            end
            dsc_exec_pkg::OP_ASR_BY_REG, dsc_exec_pkg::OP_ASR_BY_FIVE_BIT_LITERAL: begin
               result  = shift_out;
               wr_work = 1'b1;
               core_next[dsc_exec_pkg::N_BIT] = shift_out[15];
               core_next[dsc_exec_pkg::Z_BIT] = (shift_out == 16'h0000);
            end
            default: begin
               result = 16'h0000;
            end
         endcase
      end
   end

   // signed add to the chosen accumulator
   always_comb begin
      logic [39:0] ext;
      logic [39:0] shifted;
      logic [39:0] acc_old;
      logic [40:0] sum;
      logic [3:0]  mag;
      logic        ovf_acc;
      logic        ovf_all;
      ext      = 40'h00_0000_0000;
      shifted  = 40'h00_0000_0000;
      acc_old  = ACC_SEL ? acc_b_reg : acc_a_reg;
      sum      = 41'h000_0000_0000;
      mag      = 4'h0;
      ovf_acc  = 1'b0;
      ovf_all  = 1'b0;
      dsp_next = dsp_reg;
      acc_we   = 1'b0;
      ext      = {{24{src_operand_reg[15]}}, src_operand_reg};
      if (SHIFT_LITERAL[3]) begin
         mag     = 4'h0 - SHIFT_LITERAL;
         shifted = ext << mag;
      end else begin
         mag     = {1'b0, SHIFT_LITERAL[2:0]};
         shifted = 40'($signed(ext) >>> mag);
      end
      sum      = {acc_old[39], acc_old} + {shifted[39], shifted};
      acc_next = sum[39:0];
      ovf_all  = (sum[40] != sum[39]);
      ovf_acc  = ~((&sum[39:31]) | ~(|sum[39:31]));
      if (OP_VALID && op == dsc_exec_pkg::OP_ADD_ACC) begin
         acc_we = 1'b1;
         if (ACC_SEL) begin
            dsp_next[dsc_exec_pkg::OB_BIT] = ovf_acc;
            dsp_next[dsc_exec_pkg::SB_BIT] =
               dsp_reg[dsc_exec_pkg::SB_BIT] | ovf_all;
         end else begin
            dsp_next[dsc_exec_pkg::OA_BIT] = ovf_acc;
            dsp_next[dsc_exec_pkg::SA_BIT] =
               dsp_reg[dsc_exec_pkg::SA_BIT] | ovf_all;
         end
      end
   end

   // multiply pairing and prefetch addressing
   always_comb begin
      pair_ok = (op == dsc_exec_pkg::OP_SQR) ?
                (MUL_A_SEL == MUL_B_SEL) :
                (MUL_A_SEL != MUL_B_SEL);
      mul_legal = OP_VALID && pair_ok &&
                  (op == dsc_exec_pkg::OP_MAC || op == dsc_exec_pkg::OP_SQR);
      x_idx = X_SEL[3] ? (dsc_exec_pkg::X_PTR_IDX + 4'h1)
                       : dsc_exec_pkg::X_PTR_IDX;
      y_idx = Y_SEL[3] ? (dsc_exec_pkg::Y_PTR_IDX + 4'h1)
                       : dsc_exec_pkg::Y_PTR_IDX;
      x_go        = mul_legal;
      x_upd       = mul_legal && (X_SEL[2:0] != dsc_exec_pkg::MOD_PLAIN);
      x_addr_next = work_reg[x_idx];
      x_ptr_next  = work_reg[x_idx] + post_delta(X_SEL[2:0]);
      if (X_SEL[2:0] == dsc_exec_pkg::MOD_SPECIAL) begin
         x_upd       = 1'b0;
         x_go        = mul_legal && X_SEL[3];
         x_addr_next = work_reg[x_idx] + work_reg[dsc_exec_pkg::INDEX_IDX];
      end
      y_go        = mul_legal;
      y_upd       = mul_legal && (Y_SEL[2:0] != dsc_exec_pkg::MOD_PLAIN);
      y_addr_next = work_reg[y_idx];
      y_ptr_next  = work_reg[y_idx] + post_delta(Y_SEL[2:0]);
      if (Y_SEL[2:0] == dsc_exec_pkg::MOD_SPECIAL) begin
         y_upd       = 1'b0;
         y_go        = mul_legal && Y_SEL[3];
         y_addr_next = work_reg[y_idx] + work_reg[dsc_exec_pkg::INDEX_IDX];
      end
   end

   assign bus_req = (AVS_READ | AVS_WRITE) & wait_reg;
   assign bus_wr  = AVS_WRITE & ~wait_reg;

   // working registers, later writers win
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         for (int i = 0; i < dsc_exec_pkg::NUM_WORK; i++)
            work_reg[i] <= dsc_exec_pkg::WORK_RST;
      end else begin
         if (bus_wr && AVS_ADDRESS[7:6] == dsc_exec_pkg::OFS_WORK_BASE[7:6]
             && AVS_ADDRESS[1:0] == 2'h0)
            work_reg[AVS_ADDRESS[5:2]] <=
               merge16(work_reg[AVS_ADDRESS[5:2]], AVS_WRITEDATA,
                       AVS_BYTEENABLE);
         if (x_upd)
            work_reg[x_idx] <= x_ptr_next;
         if (y_upd)
            work_reg[y_idx] <= y_ptr_next;
         if (X_FETCH_VALID)
            work_reg[dsc_exec_pkg::DSP_FIRST_IDX + {2'h0, X_FETCH_DEST}]
               <= X_FETCH_DATA;
         if (Y_FETCH_VALID)
            work_reg[dsc_exec_pkg::DSP_FIRST_IDX + {2'h0, Y_FETCH_DEST}]
               <= Y_FETCH_DATA;
         if (wr_work)
            work_reg[wr_idx] <= result;
      end
   end

   // status and accumulators
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         core_reg  <= dsc_exec_pkg::CORE_STATUS_RST;
         dsp_reg   <= dsc_exec_pkg::DSP_STATUS_RST;
         acc_a_reg <= dsc_exec_pkg::ACC_RST;
         acc_b_reg <= dsc_exec_pkg::ACC_RST;
      end else begin
         core_reg <= core_next;
         dsp_reg  <= dsp_next;
         if (bus_wr && AVS_ADDRESS == dsc_exec_pkg::OFS_CORE_STATUS
             && AVS_BYTEENABLE[0] && core_next == core_reg)
            core_reg <= AVS_WRITEDATA[4:0];
         if (bus_wr && AVS_ADDRESS == dsc_exec_pkg::OFS_DSP_STATUS
             && AVS_BYTEENABLE[0] && dsp_next == dsp_reg)
            dsp_reg <= AVS_WRITEDATA[3:0];
         if (acc_we && !ACC_SEL)
            acc_a_reg <= acc_next;
         if (acc_we && ACC_SEL)
            acc_b_reg <= acc_next;
      end
   end

   // operation results toward the rest of the core
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         file_wr_reg    <= 1'b0;
         file_wdata_reg <= 16'h0000;
         illegal_reg    <= 1'b0;
         mul_go_reg     <= 1'b0;
         mul_a_reg      <= 16'h0000;
         mul_b_reg      <= 16'h0000;
         x_rd_reg       <= 1'b0;
         x_addr_reg     <= 16'h0000;
         y_rd_reg       <= 1'b0;
         y_addr_reg     <= 16'h0000;
         div_go_reg     <= 1'b0;
         dividend_reg   <= 16'h0000;
         divisor_reg    <= 16'h0000;
      end else begin
         file_wr_reg <= wr_file;
         if (wr_file)
            file_wdata_reg <= result;
         illegal_reg <= OP_VALID && (op > dsc_exec_pkg::OP_DIV ||
            ((op == dsc_exec_pkg::OP_MAC || op == dsc_exec_pkg::OP_SQR)
             && !pair_ok));
         mul_go_reg <= mul_legal;
         if (mul_legal) begin
            mul_a_reg <= work_reg[dsc_exec_pkg::DSP_FIRST_IDX
                                  + {2'h0, MUL_A_SEL}];
            mul_b_reg <= work_reg[dsc_exec_pkg::DSP_FIRST_IDX
                                  + {2'h0, MUL_B_SEL}];
         end
         x_rd_reg <= x_go;
         if (x_go)
            x_addr_reg <= x_addr_next;
         y_rd_reg <= y_go;
         if (y_go)
            y_addr_reg <= y_addr_next;
         div_go_reg <= OP_VALID && op == dsc_exec_pkg::OP_DIV;
         if (OP_VALID && op == dsc_exec_pkg::OP_DIV) begin
            dividend_reg <= base_operand_reg;
            divisor_reg  <= src_operand_reg;
         end
      end
   end

   // register read decode
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (AVS_ADDRESS[7:6] == dsc_exec_pkg::OFS_WORK_BASE[7:6]) begin
         if (AVS_ADDRESS[1:0] == 2'h0)
            rd_mux = {16'h0000, work_reg[AVS_ADDRESS[5:2]]};
      end else begin
         unique case (AVS_ADDRESS)
            dsc_exec_pkg::OFS_CORE_STATUS: rd_mux = {27'h000_0000, core_reg};
            dsc_exec_pkg::OFS_DSP_STATUS:  rd_mux = {28'h000_0000, dsp_reg};
            dsc_exec_pkg::OFS_ACC_A_LO:    rd_mux = acc_a_reg[31:0];
            dsc_exec_pkg::OFS_ACC_A_HI:    rd_mux = {24'h00_0000,
                                                     acc_a_reg[39:32]};
            dsc_exec_pkg::OFS_ACC_B_LO:    rd_mux = acc_b_reg[31:0];
            dsc_exec_pkg::OFS_ACC_B_HI:    rd_mux = {24'h00_0000,
                                                     acc_b_reg[39:32]};
            default:                       rd_mux = 32'h0000_0000;
         endcase
      end
   end

   // avalon slave: answer one cycle after the request
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         wait_reg  <= 1'b1;
         rdata_reg <= 32'h0000_0000;
      end else begin
         wait_reg <= ~bus_req;
         if (bus_req && AVS_READ)
            rdata_reg <= rd_mux;
      end
   end

   assign AVS_READDATA    = rdata_reg;
   assign AVS_WAITREQUEST = wait_reg;
   assign FILE_WR         = file_wr_reg;
   assign FILE_WDATA      = file_wdata_reg;
   assign CORE_STATUS     = core_reg;
   assign DSP_STATUS      = dsp_reg;
   assign OP_ILLEGAL      = illegal_reg;
   assign MUL_OPA         = mul_a_reg;
   assign MUL_OPB         = mul_b_reg;
   assign MUL_GO          = mul_go_reg;
   assign X_RD            = x_rd_reg;
   assign X_ADDR          = x_addr_reg;
   assign Y_RD            = y_rd_reg;
   assign Y_ADDR          = y_addr_reg;
   assign DIV_GO          = div_go_reg;
   assign DIV_DIVIDEND    = dividend_reg;
   assign DIV_DIVISOR     = divisor_reg;

endmodule : dsc_operand_and_arith_exec

/* test/fetch_model.sv */
/*
 prefetch memory model: answers a read one cycle later.
 assumes rd is a one-cycle pulse with addr valid.
*/
`timescale 1ns/1ps
module fetch_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        rd,
   input  wire logic [15:0] addr,
   output logic             valid,
   output logic      [15:0] data
);
   always_ff @(posedge clk) begin
      valid <= rd && !rst;
      data  <= rst ? 16'h0000 : rd ? addr ^ 16'hA5A5 : ~data;
   end
endmodule : fetch_model

/* test/dsc_exec_assertions.sv */
/*
 port checker of the execution datapath.
 assumes a bind onto the top module.
*/
`timescale 1ns/1ps
module dsc_exec_assertions (
   input wire logic        REF_CLK,
   input wire logic        RST,
   input wire logic        OP_VALID,
   input wire logic [3:0]  OP_CODE,
   input wire logic        TO_WORK,
   input wire logic [15:0] FILE_DATA,
   input wire logic [1:0]  MUL_A_SEL,
   input wire logic [1:0]  MUL_B_SEL,
   input wire logic [3:0]  X_SEL,
   input wire logic        FILE_WR,
   input wire logic [15:0] FILE_WDATA,
   input wire logic [4:0]  CORE_STATUS,
   input wire logic        OP_ILLEGAL,
   input wire logic        MUL_GO,
   input wire logic        X_RD,
   input wire logic        DIV_GO
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   logic pair;
   assign pair = MUL_A_SEL != MUL_B_SEL;
   a_mac_legal: assert property (OP_VALID && OP_CODE == 4'hA && pair
      |=> MUL_GO && !OP_ILLEGAL) else $error("mac pair refused");
   a_mac_self: assert property (OP_VALID && OP_CODE == 4'hA && !pair
      |=> OP_ILLEGAL && !MUL_GO && !X_RD) else $error("mac self pair taken");
   a_sqr_mixed: assert property (OP_VALID && OP_CODE == 4'hB && pair
      |=> OP_ILLEGAL && !MUL_GO) else $error("square pair taken");
   a_x_fetch: assert property (OP_VALID && OP_CODE == 4'hA && pair
      && X_SEL != 4'h7 |=> X_RD) else $error("no prefetch");
   a_div_go: assert property (OP_VALID && OP_CODE == 4'hC
      |=> DIV_GO) else $error("divide not started");
   a_asr_one: assert property (OP_VALID && OP_CODE == 4'h6
      && !TO_WORK |=> FILE_WR && $signed(FILE_WDATA) ==
      ($signed($past(FILE_DATA)) >>> 1)
      && ($past(FILE_DATA) & 16'h0001) == {15'h0000, CORE_STATUS[0]})
      else $error("shift by one wrong");
   a_lit_flags: assert property (OP_VALID && OP_CODE == 4'h9
      |=> ((CORE_STATUS ^ $past(CORE_STATUS)) & 5'h0B) == 5'h00)
      else $error("literal shift touched flags");
   a_acc_core: assert property (OP_VALID && OP_CODE == 4'h5
      |=> CORE_STATUS == $past(CORE_STATUS)) else $error("core flags moved");
endmodule : dsc_exec_assertions
bind dsc_operand_and_arith_exec dsc_exec_assertions chk (.*);

/* test/tb_dsc_operand_and_arith_exec.sv */
/*
 self-checking bench of the execution datapath.
 assumes the checker binds itself and fetch_model serves prefetches.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
$display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb_dsc_operand_and_arith_exec;
   logic        REF_CLK = 1'b0, RST = 1'b1, OP_VALID = 1'b0, TO_WORK = 1'b0;
   logic        AVS_READ = 1'b0, AVS_WRITE = 1'b0;
   logic [3:0]  OP_CODE = 4'h0, BASE_SEL = 4'h0, SRC_SEL = 4'h0;
   logic [3:0]  DEST_SEL = 4'h0, X_SEL = 4'h7, Y_SEL = 4'h7;
   logic [1:0]  MUL_A_SEL = 2'h0, MUL_B_SEL = 2'h0, X_FETCH_DEST = 2'h0;
   logic [9:0]  LITERAL = 10'h000;
   logic [15:0] FILE_DATA = 16'h0000;
   logic [7:0]  AVS_ADDRESS = 8'h00;
   logic [31:0] AVS_WRITEDATA = 32'h0000_0000, AVS_READDATA, q;
   logic        AVS_WAITREQUEST, FILE_WR, OP_ILLEGAL, MUL_GO, X_RD, Y_RD;
   logic        DIV_GO, X_FETCH_VALID, Y_FETCH_VALID;
   logic [15:0] FILE_WDATA, MUL_OPA, MUL_OPB, X_ADDR, Y_ADDR, DIV_DIVIDEND;
   logic [15:0] DIV_DIVISOR, X_FETCH_DATA, Y_FETCH_DATA;
   logic [4:0]  CORE_STATUS;
   logic [3:0]  DSP_STATUS;
   int          n_errors = 0, comparisons = 0;
   always #12.5 REF_CLK = ~REF_CLK;
   dsc_operand_and_arith_exec DUT (.*, .SHIFT_LITERAL(4'h0), .ACC_SEL(1'b0),
      .Y_FETCH_DEST(2'h0), .AVS_BYTEENABLE(4'hF));
   fetch_model xmem (.clk(REF_CLK), .rst(RST), .rd(X_RD), .addr(X_ADDR),
      .valid(X_FETCH_VALID), .data(X_FETCH_DATA));
   fetch_model ymem (.clk(REF_CLK), .rst(RST), .rd(Y_RD), .addr(Y_ADDR),
      .valid(Y_FETCH_VALID), .data(Y_FETCH_DATA));
   task automatic op(input logic [3:0] c, b, s, d, input logic [9:0] l);
      @(posedge REF_CLK);
      OP_VALID <= 1'b1;
      OP_CODE <= c;
      BASE_SEL <= b;
      SRC_SEL <= s;
      DEST_SEL <= d;
      LITERAL <= l;
      @(posedge REF_CLK);
      OP_VALID <= 1'b0;
      #1;
   endtask : op
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge REF_CLK);
      AVS_READ <= !w;
      AVS_WRITE <= w;
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      @(posedge REF_CLK);
      while (AVS_WAITREQUEST) @(posedge REF_CLK);
      q = AVS_READDATA;
      AVS_READ <= 1'b0;
      AVS_WRITE <= 1'b0;
   endtask : bus
   task automatic test_done();
      if (n_errors == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : test_done
   initial begin
      repeat (8) @(posedge REF_CLK);
      RST <= 1'b0;
      bus(1'b1, 8'h44, 32'h0000_7FFF);
      bus(1'b1, 8'h00, 32'h0000_0001);
      op(4'h4, 4'h1, 4'h0, 4'h2, 10'h005);
      `CHK(CORE_STATUS, 5'h0E)
      bus(1'b0, 8'h48, 32'h0000_0000);
      `CHK(q[15:0], 16'h8005)
      bus(1'b1, 8'h40, 32'h0000_0001);
      FILE_DATA <= 16'hFFFF;
      op(4'h1, 4'h0, 4'h0, 4'h0, 10'h000);
      `CHK(FILE_WDATA, 16'h0000)
      `CHK(FILE_WR, 1'b1)
      `CHK(CORE_STATUS, 5'h03)
      FILE_DATA <= 16'h8001;
      op(4'h6, 4'h0, 4'h0, 4'h0, 10'h000);
      `CHK(FILE_WDATA, 16'hC000)
      `CHK(CORE_STATUS, 5'h07)
      op(4'h9, 4'h2, 4'h0, 4'h3, 10'h004);
      bus(1'b0, 8'h4C, 32'h0000_0000);
      `CHK(q[15:0], 16'hF800)
      op(4'h2, 4'h0, 4'h0, 4'h3, 10'h3FF);
      `CHK(CORE_STATUS, 5'h06)
      bus(1'b0, 8'h4C, 32'h0000_0000);
      `CHK(q[15:0], 16'hFC00)
      bus(1'b1, 8'h50, 32'h0000_1111);
      bus(1'b1, 8'h54, 32'h0000_2222);
      bus(1'b1, 8'h60, 32'h0000_0100);
      bus(1'b1, 8'h68, 32'h0000_0200);
      op(4'hA, 4'h0, 4'h0, 4'h0, 10'h000);
      `CHK(OP_ILLEGAL, 1'b1)
      MUL_B_SEL <= 2'h1;
      X_SEL <= 4'h1;
      X_FETCH_DEST <= 2'h2;
      Y_SEL <= 4'h4;
      op(4'hB, 4'h0, 4'h0, 4'h0, 10'h000);
      `CHK(OP_ILLEGAL, 1'b1)
      op(4'hA, 4'h0, 4'h0, 4'h0, 10'h000);
      `CHK(MUL_OPA, 16'h1111)
      `CHK(MUL_OPB, 16'h2222)
      `CHK(X_ADDR, 16'h0100)
      `CHK(Y_RD, 1'b1)
      `CHK(Y_ADDR, 16'h0200)
      op(4'hC, 4'h4, 4'h5, 4'h0, 10'h000);
      `CHK(DIV_DIVIDEND, 16'h1111)
      `CHK(DIV_DIVISOR, 16'h2222)
      bus(1'b0, 8'h60, 32'h0000_0000);
      `CHK(q[15:0], 16'h0102)
      bus(1'b0, 8'h58, 32'h0000_0000);
      `CHK(q[15:0], 16'hA4A5)
      bus(1'b0, 8'h30, 32'h0000_0000);
      `CHK(q, 32'h0000_0000)
      op(4'h5, 4'h0, 4'h0, 4'h0, 10'h000);
      `CHK(DSP_STATUS, 4'h0)
      bus(1'b0, 8'h08, 32'h0000_0000);
      `CHK(q, 32'h0000_0001)
      test_done();
   end
   // whole run is under 300 cycles
   initial begin
      repeat (2000) @(posedge REF_CLK);
      n_errors++;
      test_done();
   end
endmodule : tb_dsc_operand_and_arith_exec
